/* File: bench/prpi_link_assertions.sv */
/*
 * Checker for the panel link and the stream ports at both ends.
 * Assumes one shared clock and reset; instantiated beside the link.
 */
`timescale 1ns/1ns
`default_nettype none

module prpi_link_assertions #(
  parameter int LINE_CYC = 112
) (
  // system
  input wire logic       CLOCK_I,
  input wire logic       RST_N_I,
  // link
  input wire logic       pixel_sample_clock,
  input wire logic       line_sync,
  input wire logic       frame_sync,
  input wire logic       display_enable_window,
  input wire logic [5:0] red_bits,
  input wire logic [5:0] green_bits,
  input wire logic [5:0] blue_bits,
  // host end
  input wire logic       PANEL_POWER_I,
  input wire logic       PIX_VALID_I,
  input wire logic       PIX_READY_O,
  input wire logic       UNDERFLOW_O,
  // panel end
  input wire logic       PIX_VALID_O,
  input wire logic       PIX_READY_I,
  input wire logic       OVERRUN_O
);
  // **********
  // host buffer fill
  // **********
  // a pop shows one edge late, so the count is a bound, not a mirror
  int occ_r;

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I)
      occ_r <= 0;
    else
      occ_r <= occ_r + int'(PIX_VALID_I && PIX_READY_O) - int'($rose(pixel_sample_clock) && display_enable_window);
  end

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_N_I);

  // **********
  // link
  // **********
  AST_PCLK_HIGH: assert property (disable iff (!RST_N_I || !PANEL_POWER_I)
    $rose(pixel_sample_clock) |-> pixel_sample_clock[*4] ##1 !pixel_sample_clock)
    else $error("pixel clock high phase wrong");
  AST_LINK_ON_RISE: assert property (disable iff (!RST_N_I || !PANEL_POWER_I)
    !$stable({line_sync, frame_sync, display_enable_window, red_bits, green_bits, blue_bits})
      |-> $rose(pixel_sample_clock))
    else $error("link changed away from a pixel clock rise");
  AST_EN_BLANK_SYNC: assert property (
    display_enable_window |-> !line_sync && !frame_sync)
    else $error("enable window during a sync pulse");
  AST_LINE_PERIOD: assert property (disable iff (!RST_N_I || !PANEL_POWER_I)
    $rose(line_sync) |-> ##LINE_CYC $rose(line_sync))
    else $error("line period wrong");
  AST_UNDERFLOW_BLANK: assert property (
    UNDERFLOW_O |-> !display_enable_window)
    else $error("empty slot sent with enable high");
  AST_HOST_BUF_BOUND: assert property (
    occ_r >= 0 && occ_r <= 2)
    else $error("host buffer over or under run");
  AST_POWER_OFF_LOW: assert property (
    !PANEL_POWER_I && !$past(PANEL_POWER_I)
      |-> {pixel_sample_clock, line_sync, frame_sync, display_enable_window, red_bits, green_bits, blue_bits} == '0)
    else $error("link driven while panel unpowered");

  // **********
  // panel stream
  // **********
  AST_VALID_HOLD: assert property (
    PIX_VALID_O && !PIX_READY_I |=> PIX_VALID_O)
    else $error("beat withdrawn before taken");
  AST_OVERRUN_STALL: assert property (
    OVERRUN_O |-> $past(PIX_VALID_O) && !$past(PIX_READY_I))
    else $error("overrun without a stalled full buffer");

  CVR_OVERRUN: cover property (OVERRUN_O);
  CVR_UNDERFLOW: cover property (UNDERFLOW_O);
  CVR_BEAT: cover property (PIX_VALID_O && PIX_READY_I);
endmodule : prpi_link_assertions

`default_nettype wire

/* File: bench/testbench.sv */
/*
 * Bench: host and panel ends on one link, random pixels in, beats checked.
 * Assumes the rtl header, package and interface are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none

module testbench;
  localparam int HA = 8;
  localparam int VA = 4;
  localparam int HF = 2;
  localparam int HS = 2;
  localparam int HB = 2;
  localparam int VF = 1;
  localparam int VS = 1;
  localparam int VB = 1;
  localparam int HC = 4;
  localparam int LINE_CYC = (HA + HF + HS + HB) * 2 * HC;
  localparam int FRAME_CYC = LINE_CYC * (VA + VF + VS + VB);

  logic clock_i, rst_n_i, pix_valid_i, pix_ready_i, panel_power_i, stall, pclk_d;
  logic pix_ready_o, underflow_o, pix_valid_o, pix_first_o, overrun_o, frame_start_o;
  prpi_pkg::prpi_pixel_s pix_data_i;
  prpi_pkg::prpi_pixel_s pix_data_o;
  prpi_pkg::prpi_coord_t pix_x_o;
  prpi_pkg::prpi_coord_t pix_y_o;
  prpi_pkg::prpi_beat_s  mon_b;
  prpi_pkg::prpi_beat_s  exp_q[$];
  prpi_pkg::prpi_pixel_s wire_q[$];
  int                    err_count;
  int                    samples_checked;
  int                    seed;
  int                    ovr_count;
  int                    und_count;
  int                    k;
  int                    cyc;
  int                    fs_last;

  prpi_if link_if ();

  prpi_host #(.H_ACTIVE(HA), .H_FRONT(HF), .H_SYNC(HS), .H_BACK(HB), .V_ACTIVE(VA), .V_FRONT(VF), .V_SYNC(VS),
    .V_BACK(VB), .HALF_CYC(HC)) prpi_host_inst (.CLOCK_I(clock_i), .RST_N_I(rst_n_i), .PIX_VALID_I(pix_valid_i),
    .PIX_READY_O(pix_ready_o), .PIX_DATA_I(pix_data_i), .PANEL_POWER_I(panel_power_i),
    .FRAME_START_O(frame_start_o), .UNDERFLOW_O(underflow_o), .LINK(link_if));
  prpi_panel #(.H_ACTIVE(HA), .V_ACTIVE(VA)) prpi_panel_inst (.CLOCK_I(clock_i), .RST_N_I(rst_n_i),
    .LINK(link_if), .PIX_VALID_O(pix_valid_o), .PIX_READY_I(pix_ready_i), .PIX_DATA_O(pix_data_o),
    .PIX_X_O(pix_x_o), .PIX_Y_O(pix_y_o), .PIX_FIRST_O(pix_first_o), .OVERRUN_O(overrun_o));
  prpi_link_assertions #(.LINE_CYC(LINE_CYC)) prpi_link_assertions_inst (.CLOCK_I(clock_i), .RST_N_I(rst_n_i),
    .pixel_sample_clock(link_if.pixel_sample_clock), .line_sync(link_if.line_sync),
    .frame_sync(link_if.frame_sync), .display_enable_window(link_if.display_enable_window),
    .red_bits(link_if.red_bits), .green_bits(link_if.green_bits), .blue_bits(link_if.blue_bits),
    .PANEL_POWER_I(panel_power_i), .PIX_VALID_I(pix_valid_i), .PIX_READY_O(pix_ready_o),
    .UNDERFLOW_O(underflow_o), .PIX_VALID_O(pix_valid_o), .PIX_READY_I(pix_ready_i), .OVERRUN_O(overrun_o));

  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  // **********
  // compare and close
  // **********
  task automatic check_pix(input prpi_pkg::prpi_pixel_s got, input prpi_pkg::prpi_pixel_s exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t pixel %h expected %h", $time, got, exp);
    end
  endtask : check_pix

  task automatic check_num(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s is %0h expected %0h", $time, what, got, exp);
    end
  endtask : check_num

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // **********
  // pixel source: request held until ready is seen at an edge
  // **********
  task automatic send_pixels(input int n);
    logic gap;
    logic acc;
    prpi_pkg::prpi_beat_s b;
    int i;
    i = 0;
    while (i < n) begin
      gap = ($random(seed) % 4) == 0;
      pix_valid_i <= !gap;
      pix_data_i <= 18'($random(seed));
      do begin
        @(negedge clock_i);
        acc = pix_ready_o;
        @(posedge clock_i);
      end while (!gap && acc !== 1'b1);
      if (!gap) begin
        b.pix = pix_data_i;
        b.x = 11'(k % HA);
        b.y = 11'((k / HA) % VA);
        b.first = (k % (HA * VA) == 0);
        exp_q.push_back(b);
        wire_q.push_back(b.pix);
        k++;
        i++;
      end
    end
    pix_valid_i <= 1'b0;
  endtask : send_pixels

  always @(posedge clock_i) pix_ready_i <= !stall && ($random(seed) % 2 != 0);

  // **********
  // watchers
  // **********
  always @(negedge clock_i) begin
    if (underflow_o === 1'b1)
      und_count++;
    // the dropped beat is the one behind the two held
    if (overrun_o === 1'b1) begin
      ovr_count++;
      if (exp_q.size() > 2)
        exp_q.delete(2);
    end
    if (pix_valid_o === 1'b1 && pix_ready_i === 1'b1) begin
      if (exp_q.size() == 0)
        check_num(32'h1, 32'h0, "unexpected beat");
      else begin
        mon_b = exp_q.pop_front();
        check_pix(pix_data_o, mon_b.pix);
        check_num({21'h0, pix_x_o}, {21'h0, mon_b.x}, "column");
        check_num({21'h0, pix_y_o}, {21'h0, mon_b.y}, "line");
        check_num({31'h0, pix_first_o}, {31'h0, mon_b.first}, "first flag");
      end
    end
  end

  always @(negedge clock_i) begin
    if (pclk_d === 1'b1 && link_if.pixel_sample_clock === 1'b0 && link_if.display_enable_window === 1'b1) begin
      if (wire_q.size() == 0)
        check_num(32'h1, 32'h0, "unexpected slot");
      else
        check_pix({link_if.red_bits, link_if.green_bits, link_if.blue_bits}, wire_q.pop_front());
    end
    pclk_d = link_if.pixel_sample_clock;
  end

  // frame starts come one whole frame of slots apart
  always @(negedge clock_i) begin
    cyc++;
    if (frame_start_o === 1'b1) begin
      if (fs_last >= 0)
        check_num(cyc - fs_last, FRAME_CYC, "frame period");
      fs_last = cyc;
    end
  end

  // **********
  // main sequence
  // **********
  initial begin
    seed = 32'h5d22;
    {err_count, samples_checked, ovr_count, und_count, k} = '0;
    {pix_valid_i, pix_ready_i, panel_power_i, stall, pclk_d} = '0;
    pix_data_i = '0;
    cyc = 0;
    fs_last = -1;
    rst_n_i = 1'b0;
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    // power stays off until the host buffer is full, so slot 0 finds a pixel
    fork
      send_pixels(96);
      begin
        for (int j = 0; j < 40 && pix_ready_o !== 1'b0; j++)
          @(negedge clock_i);
        check_num({31'h0, pix_ready_o}, 32'h0, "ready while full");
        @(posedge clock_i);
        panel_power_i <= 1'b1;
      end
      begin
        repeat (880) @(posedge clock_i);
        stall <= 1'b1;
        repeat (96) @(posedge clock_i);
        stall <= 1'b0;
      end
    join
    check_num({31'h0, ovr_count >= 2}, 32'h1, "overruns");
    $display("test stream and stall done");
    repeat (2 * FRAME_CYC) @(posedge clock_i);
    check_num(exp_q.size(), 32'h0, "beats left");
    check_num({31'h0, fs_last >= 0}, 32'h1, "frame start seen");
    check_num({31'h0, und_count > 0}, 32'h1, "underflow");
    $display("test underflow done");
    panel_power_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    @(negedge clock_i);
    check_num({10'h0, link_if.pixel_sample_clock, link_if.line_sync, link_if.frame_sync,
      link_if.display_enable_window, link_if.red_bits, link_if.green_bits, link_if.blue_bits},
      32'h0, "link unpowered");
    $display("test power off done");
    print_verdict();
  end

  initial begin
    repeat (6 * FRAME_CYC + 2000) @(posedge clock_i);
    err_count++;
    $display("[ERR] %0t run did not finish", $time);
    print_verdict();
  end
endmodule : testbench

`default_nettype wire

/* File: rtl/prpi_host.sv */
/*
 * Host end of the parallel RGB link: divides the system clock into the
 * pixel clock, runs the line and frame timing and sends buffered pixels
 * inside the enable window.
 * Assumes a 20 MHz CLOCK_I and a pixel source that may stall; a panel that
 * samples on the falling pixel clock edge.
 */
`timescale 1ns/1ns
`default_nettype none
`include "prpi_regs.svh"

// Functional notes
// - panel shows 800 columns by 600 lines
// - host sends 18 data bits plus syncs
// - six bits form one sub-pixel brightness
// - bit 5 heaviest, bit 0 lightest
// - host drives pixel clock, one pixel per period
// - pixel clock captures data and enable
// - enable is sampled on falling edge
// - data valid at falling edges while enabled
// - frame sync synchronous to pixel clock
// - line sync synchronous to pixel clock
// - timing follows 800x600 60 Hz standard (line and frame counts kept; the 400 ns pixel clock gives about 3.8 Hz)
// - outputs low while panel power off
module prpi_host #(
  parameter int H_ACTIVE = `PRPI_H_ACTIVE,
  parameter int H_FRONT  = `PRPI_H_FRONT,
  parameter int H_SYNC   = `PRPI_H_SYNC,
  parameter int H_BACK   = `PRPI_H_BACK,
  parameter int V_ACTIVE = `PRPI_V_ACTIVE,
  parameter int V_FRONT  = `PRPI_V_FRONT,
  parameter int V_SYNC   = `PRPI_V_SYNC,
  parameter int V_BACK   = `PRPI_V_BACK,
  parameter int HALF_CYC = `PRPI_PCLK_HALF_CYC
) (
  // system
  input  wire logic                  CLOCK_I,
  input  wire logic                  RST_N_I,
  // pixel stream from the frame source
  input  wire logic                  PIX_VALID_I,
  output logic                       PIX_READY_O,
  input  wire prpi_pkg::prpi_pixel_s PIX_DATA_I,
  // control and status
  input  wire logic                  PANEL_POWER_I,
  output logic                       FRAME_START_O,
  output logic                       UNDERFLOW_O,
  // link to the panel
  prpi_if.host                       LINK
);

  localparam int H_TOTAL = H_ACTIVE + H_FRONT + H_SYNC + H_BACK;
  localparam int V_TOTAL = V_ACTIVE + V_FRONT + V_SYNC + V_BACK;

  // true while cnt lies in [start, start + len)
  function automatic logic in_span(input prpi_pkg::prpi_coord_t cnt, input int start, input int len);
    in_span = (int'(cnt) >= start) && (int'(cnt) < start + len);
  endfunction : in_span

  // ****************************************************************
  // pixel clock divider
  // ****************************************************************
  // 40 MHz is out of reach from 20 MHz; the divider sets a slower but
  // otherwise faithful pixel clock with a 50 % duty cycle
  logic [7:0] div_r;
  logic       pclk_r;
  logic       tick_w;
  logic       rise_w;

  assign tick_w = (div_r == 8'(HALF_CYC - 1));
  assign rise_w = tick_w & ~pclk_r;

  // panel power low parks the divider so the link idles low
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I || !PANEL_POWER_I) begin
      div_r  <= 8'h00;
      pclk_r <= 1'b0;
    end else if (tick_w) begin
      div_r  <= 8'h00;
      pclk_r <= ~pclk_r;
    end else begin
      div_r  <= div_r + 8'h01;
    end
  end

  // ****************************************************************
  // line and frame counters
  // ****************************************************************
  prpi_pkg::prpi_coord_t h_r;
  prpi_pkg::prpi_coord_t v_r;
  logic                  active_w;

  assign active_w = (int'(h_r) < H_ACTIVE) && (int'(v_r) < V_ACTIVE);
  // counts move on each pixel clock rise; the link shows the slot of the old count

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I || !PANEL_POWER_I) begin
      h_r <= '0;
      v_r <= '0;
    end else if (rise_w) begin
      if (h_r == prpi_pkg::prpi_coord_t'(H_TOTAL - 1)) begin
        h_r <= '0;
        v_r <= (v_r == prpi_pkg::prpi_coord_t'(V_TOTAL - 1)) ? '0 : v_r + 11'h001;
      end else begin
        h_r <= h_r + 11'h001;
      end
    end
  end

  // ****************************************************************
  // two-entry input buffer
  // ****************************************************************
  prpi_pkg::prpi_pixel_s buf_r [2];
  logic [1:0]            cnt_r;
  logic [1:0]            cnt_nxt;
  logic                  need_w;
  logic                  pop_w;
  logic                  push_w;
  logic                  wr_idx_w;

  // pops happen only at the rise that opens an active slot
  assign need_w   = rise_w & active_w;
  assign pop_w    = need_w & (cnt_r != 2'h0);
  assign push_w   = PIX_VALID_I & PIX_READY_O;
  assign wr_idx_w = 1'(cnt_r - {1'b0, pop_w});
  assign cnt_nxt  = cnt_r + {1'b0, push_w} - {1'b0, pop_w};

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      cnt_r       <= 2'h0;
      PIX_READY_O <= 1'b0;
    end else begin
      cnt_r       <= cnt_nxt;
      PIX_READY_O <= (cnt_nxt != 2'h2);
    end
  end

  // the source sees ready one cycle late, so a slot freed by a pop is
  // offered a cycle later; at one pixel per eight cycles this costs nothing
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      buf_r[0] <= '0;
      buf_r[1] <= '0;
    end else begin
      if (pop_w) begin
        buf_r[0] <= buf_r[1];
      end
      if (push_w) begin
        buf_r[wr_idx_w] <= PIX_DATA_I;
      end
    end
  end

  // ****************************************************************
  // link outputs
  // ****************************************************************
  // everything changes on the rising pixel clock, half a period before the
  // falling edge at which the panel samples it
  logic                  hs_r;
  logic                  vs_r;
  logic                  de_r;
  prpi_pkg::prpi_pixel_s pix_r;

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I || !PANEL_POWER_I) begin
      hs_r <= 1'b0;
      vs_r <= 1'b0;
    end else if (rise_w) begin
      hs_r <= in_span(h_r, H_ACTIVE + H_FRONT, H_SYNC);
      vs_r <= in_span(v_r, V_ACTIVE + V_FRONT, V_SYNC);
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I || !PANEL_POWER_I) begin
      de_r  <= 1'b0;
      pix_r <= '0;
    end else if (rise_w) begin
      // an empty buffer leaves the slot blank rather than repeating a pixel
      de_r  <= pop_w;
      pix_r <= pop_w ? buf_r[0] : '0;
    end
  end

  // frame start marks the slot of pixel (0,0); underflow marks an active
  // slot sent blank because the buffer had run dry
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      FRAME_START_O <= 1'b0;
      UNDERFLOW_O   <= 1'b0;
    end else begin
      FRAME_START_O <= rise_w & (h_r == '0) & (v_r == '0);
      UNDERFLOW_O   <= need_w & (cnt_r == 2'h0);
    end
  end

  assign LINK.pixel_sample_clock    = pclk_r;
  assign LINK.line_sync             = hs_r;
  assign LINK.frame_sync            = vs_r;
  assign LINK.display_enable_window = de_r;
  assign LINK.red_bits              = pix_r.red;
  assign LINK.green_bits            = pix_r.green;
  assign LINK.blue_bits             = pix_r.blue;

endmodule : prpi_host

`default_nettype wire

/* File: rtl/prpi_if.sv */
/*
 * The parallel RGB link between a display controller and the panel input.
 * Assumes the host end drives every signal; the panel end only listens.
 */
`timescale 1ns/1ns
`default_nettype none
`include "prpi_regs.svh"

interface prpi_if;
  logic                        pixel_sample_clock;
  logic                        line_sync;
  logic                        frame_sync;
  logic                        display_enable_window;
  // red_bits[5] is red_bit5 ... red_bits[0] is red_bit0, likewise green and blue
  logic [`PRPI_COLOR_BITS-1:0] red_bits;
  logic [`PRPI_COLOR_BITS-1:0] green_bits;
  logic [`PRPI_COLOR_BITS-1:0] blue_bits;

  modport host (
    output pixel_sample_clock, line_sync, frame_sync, display_enable_window,
    output red_bits, green_bits, blue_bits
  );
  modport panel (
    input pixel_sample_clock, line_sync, frame_sync, display_enable_window,
    input red_bits, green_bits, blue_bits
  );
endinterface : prpi_if

`default_nettype wire

/* File: rtl/prpi_panel.sv */
/*
 * Panel end of the parallel RGB link: recovers the pixel clock by sampling,
 * captures pixels in the enable window and hands them on with their place.
 * Assumes the link pins are asynchronous to CLOCK_I and a pixel clock well
 * below a quarter of CLOCK_I, so every level is seen for several cycles.
 */
`timescale 1ns/1ns
`default_nettype none
`include "prpi_regs.svh"

module prpi_panel #(
  parameter int H_ACTIVE = `PRPI_H_ACTIVE,
  parameter int V_ACTIVE = `PRPI_V_ACTIVE
) (
  // system
  input  wire logic                CLOCK_I,
  input  wire logic                RST_N_I,
  // link from the host
  prpi_if.panel                    LINK,
  // captured pixel stream
  output logic                     PIX_VALID_O,
  input  wire logic                PIX_READY_I,
  output prpi_pkg::prpi_pixel_s    PIX_DATA_O,
  output prpi_pkg::prpi_coord_t    PIX_X_O,
  output prpi_pkg::prpi_coord_t    PIX_Y_O,
  output logic                     PIX_FIRST_O,
  // status
  output logic                     OVERRUN_O
);

  localparam int NB = 3 + 1 + 3 * `PRPI_COLOR_BITS;

  // take a new level only once the last two stages agree
  function automatic logic [2:0] settle(input logic [2:0] a, input logic [2:0] b, input logic [2:0] old);
    settle = (a & b) | (old & (a | b));
  endfunction : settle

  // ****************************************************************
  // three-stage synchronisers
  // ****************************************************************
  logic [NB-1:0] s1_r;
  logic [NB-1:0] s2_r;
  logic [NB-1:0] s3_r;
  logic [2:0]    filt_r;
  logic [2:0]    filt_nxt;
  logic          de_s;
  prpi_pkg::prpi_pixel_s pix_s;

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= {LINK.pixel_sample_clock, LINK.line_sync, LINK.frame_sync, LINK.display_enable_window,
               LINK.red_bits, LINK.green_bits, LINK.blue_bits};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // filt: [2] pixel clock, [1] line sync, [0] frame sync
  assign filt_nxt = settle(s2_r[NB-1 -: 3], s3_r[NB-1 -: 3], filt_r);
  assign de_s     = s3_r[NB-4];
  assign pix_s    = s3_r[3*`PRPI_COLOR_BITS-1:0];

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      filt_r <= '0;
    end else begin
      filt_r <= filt_nxt;
    end
  end

  logic fall_w;
  logic line_w;
  logic frame_w;
  assign fall_w  = filt_r[2] & ~filt_nxt[2];
  assign line_w  = ~filt_r[1] & filt_nxt[1];
  assign frame_w = ~filt_r[0] & filt_nxt[0];

  // ****************************************************************
  // placement on the 800 x 600 grid
  // ****************************************************************
  prpi_pkg::prpi_coord_t x_r;
  prpi_pkg::prpi_coord_t y_r;
  logic                  first_r;
  logic                  take_w;
  assign take_w = fall_w & de_s;

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      x_r     <= '0;
      y_r     <= '0;
      first_r <= 1'b1;
    end else if (frame_w) begin
      x_r     <= '0;
      y_r     <= '0;
      first_r <= 1'b1;
    end else if (take_w) begin
      first_r <= 1'b0;
      if (x_r == prpi_pkg::prpi_coord_t'(H_ACTIVE - 1)) begin
        x_r <= '0;
        y_r <= (y_r == prpi_pkg::prpi_coord_t'(V_ACTIVE - 1)) ? '0 : y_r + 11'h001;
      end else begin
        x_r <= x_r + 11'h001;
      end
    end else if (line_w && x_r != '0) begin
      // a short line is closed so the next one starts at the left edge
      x_r <= '0;
      y_r <= (y_r == prpi_pkg::prpi_coord_t'(V_ACTIVE - 1)) ? '0 : y_r + 11'h001;
    end
  end

  // ****************************************************************
  // two-entry output buffer
  // ****************************************************************
  // the link cannot be stalled: a beat arriving with both entries held is lost
  prpi_pkg::prpi_beat_s buf_r [2];
  logic [1:0]           cnt_r;
  logic                 pop_w;
  logic                 push_w;
  logic                 wr_idx_w;
  prpi_pkg::prpi_beat_s beat_w;

  assign pop_w    = PIX_VALID_O & PIX_READY_I;
  assign push_w   = take_w & ((cnt_r != 2'h2) | pop_w);
  assign wr_idx_w = 1'(cnt_r - {1'b0, pop_w});
  assign beat_w   = '{pix: pix_s, x: x_r, y: y_r, first: first_r};

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      cnt_r <= 2'h0;
    end else begin
      cnt_r <= cnt_r + {1'b0, push_w} - {1'b0, pop_w};
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      buf_r[0] <= '0;
      buf_r[1] <= '0;
    end else begin
      if (pop_w) begin
        buf_r[0] <= buf_r[1];
      end
      if (push_w) begin
        buf_r[wr_idx_w] <= beat_w;
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      PIX_VALID_O <= 1'b0;
      OVERRUN_O   <= 1'b0;
    end else begin
      PIX_VALID_O <= (cnt_r + {1'b0, push_w} - {1'b0, pop_w}) != 2'h0;
      OVERRUN_O   <= take_w & ~push_w;
    end
  end

  assign PIX_DATA_O  = buf_r[0].pix;
  assign PIX_X_O     = buf_r[0].x;
  assign PIX_Y_O     = buf_r[0].y;
  assign PIX_FIRST_O = buf_r[0].first;

endmodule : prpi_panel

`default_nettype wire

/* File: rtl/prpi_pkg.sv */
/*
 * Types shared by both ends of the parallel RGB panel link.
 * Assumes prpi_regs.svh sits on the include path.
 */
`include "prpi_regs.svh"

package prpi_pkg;

  typedef logic [`PRPI_COLOR_BITS-1:0] prpi_color_t;
  typedef logic [10:0]                 prpi_coord_t;

  // bit 5 of each channel is the heaviest weight, bit 0 the lightest
  typedef struct packed {
    prpi_color_t red;
    prpi_color_t green;
    prpi_color_t blue;
  } prpi_pixel_s;

  typedef struct packed {
    prpi_pixel_s pix;
    prpi_coord_t x;
    prpi_coord_t y;
    logic        first;
  } prpi_beat_s;

endpackage : prpi_pkg

/* File: rtl/prpi_regs.svh */
/*
 * Constants of the parallel RGB panel link: frame geometry, video timing
 * and the pixel clock divider.
 * Assumes a 20 MHz system clock on both ends and is included by its bare name.
 */
`ifndef PRPI_REGS_SVH
`define PRPI_REGS_SVH

// ****************************************************************
// frame geometry
// ****************************************************************
`define PRPI_COLOR_BITS    6
`define PRPI_H_ACTIVE      800
`define PRPI_V_ACTIVE      600

// ****************************************************************
// line and frame timing, in pixel clocks and in lines
// ****************************************************************
`define PRPI_H_FRONT       40
`define PRPI_H_SYNC        128
`define PRPI_H_BACK        88
`define PRPI_V_FRONT       1
`define PRPI_V_SYNC        4
`define PRPI_V_BACK        23

// ****************************************************************
// clocks
// ****************************************************************
`define PRPI_SYS_PERIOD_NS  50
`define PRPI_PCLK_TYP_MHZ   40
`define PRPI_PCLK_PERIOD_NS 400
`define PRPI_PCLK_HALF_CYC  (`PRPI_PCLK_PERIOD_NS / (2 * `PRPI_SYS_PERIOD_NS))

`endif
